// [design/lpm_pkg.sv]
// Purpose: Shared constants for the low-power mode controller
// Assumes: 32-bit APB register bus, one 40 MHz clock
// Notes:   Mode bit positions follow the processor status word layout
package lpm_pkg;
  // Register byte offsets
  localparam logic [7:0] LPM_OFF_MODE   = 8'h00;   // Mode control bits
  localparam logic [7:0] LPM_OFF_ENABLE = 8'h04;   // Module enable bank
  localparam logic [7:0] LPM_OFF_STATUS = 8'h08;   // Read-only clock state
  // Mode field positions inside the mode register
  localparam int LPM_BIT_HALT  = 4;                // core_halt_bit
  localparam int LPM_BIT_OSC   = 5;                // oscillator_off_bit
  localparam int LPM_BIT_LO    = 6;                // sys_clk_gen_bit_lo
  localparam int LPM_BIT_HI    = 7;                // sys_clk_gen_bit_hi
  localparam int LPM_MODE_W    = 4;                // Width of mode field
  localparam int LPM_MODULES   = 8;                // Peripheral enables
  // Reset values
  localparam logic [3:0] LPM_MODE_RST   = 4'h0;    // Full run state
  localparam logic [7:0] LPM_ENABLE_RST = 8'hFF;   // All modules running
  // Master clock is this multiple of the auxiliary clock
  localparam int         LPM_MULT   = 32;
  localparam logic [4:0] LPM_DIV_MAX = 5'(LPM_MULT - 1);
  // Operating states
  typedef enum logic [2:0] {
    full_run_state, sleep_level_zero, sleep_level_one,
    sleep_level_two, sleep_level_three, sleep_level_four
  } lpm_mode_e;
endpackage

// [design/lpm_controller.sv]
// Purpose: Operating-mode and clock-gating controller with APB registers
// Assumes: i_irq and i_return_from_interrupt_instr come from logic on i_clock, no synchroniser
// Notes:   Clock outputs are enables; the fabric clock never stops
// Notes on behaviour
// - Active state plus five selectable sleep levels
// - Level zero: core halted, everything else runs
// - Level one: core halted, loop control frozen
// - Level two: master clock and loop stopped
// - Level three: also oscillator DC generator off
// - Level four: crystal stopped, auxiliary clock off
// - Interrupt wakes; return restores previous sleep level
// - Auxiliary at crystal rate, master is multiple
// - Module enables gate peripherals; registers stay accessible
// - Four mode bits select the operating state
// - Reset clears oscillator-off; setting it together with halt stops crystal
// - Clear forces lowest frequency; loop starts after
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lpm_controller
  import lpm_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_irq,
  input  wire logic        i_return_from_interrupt_instr,
  output logic             o_cpu_run,
  output logic             o_master_on,
  output logic             o_aux_tick,
  output logic             o_loop_run,
  output logic             o_dco_dc_on,
  output logic             o_dco_min_freq,
  output logic             o_xtal_on,
  output logic [7:0]       o_module_en,
  output logic [2:0]       o_mode
);

  logic [LPM_MODE_W-1:0]  mode_bits;      // Live mode bits
  logic [LPM_MODE_W-1:0]  saved_bits;     // Bits held across a wake
  logic                   in_handler;     // Woken by interrupt, not yet returned
  logic [LPM_MODULES-1:0] module_en;      // Peripheral enable bank
  logic [4:0]             div_cnt;        // Auxiliary divider
  logic                   cleared;        // Low after reset until first edge
  logic                   wr_en;          // APB write accepted
  logic                   rd_en;          // APB read accepted
  logic                   hit;            // Address is mapped
  lpm_mode_e              cur_mode;       // Decoded operating state

  // Turn the four mode bits into an operating state
  function automatic lpm_mode_e decode_mode(input logic [LPM_MODE_W-1:0] b);
    lpm_mode_e m;
    m = full_run_state;
    if (b[LPM_BIT_HALT-LPM_BIT_HALT]) begin
      if (b[LPM_BIT_OSC-LPM_BIT_HALT]) begin
        m = sleep_level_four;
      end else if (b[LPM_BIT_HI-LPM_BIT_HALT] && b[LPM_BIT_LO-LPM_BIT_HALT]) begin
        m = sleep_level_three;
      end else if (b[LPM_BIT_HI-LPM_BIT_HALT]) begin
        m = sleep_level_two;
      end else if (b[LPM_BIT_LO-LPM_BIT_HALT]) begin
        m = sleep_level_one;
      end else begin
        m = sleep_level_zero;
      end
    end
    return m;
  endfunction

  // Address match, used by both read and write paths
  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
    return (a == {24'h000000, off});
  endfunction

  assign hit   = is_reg(i_paddr, LPM_OFF_MODE) || is_reg(i_paddr, LPM_OFF_ENABLE)
              || is_reg(i_paddr, LPM_OFF_STATUS);
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  // Zero wait states; unmapped addresses answer with an error
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign cur_mode  = decode_mode(mode_bits);

  // Mode bits: interrupt wake beats software write, return restores
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_bits  <= LPM_MODE_RST;
      saved_bits <= LPM_MODE_RST;
      in_handler <= 1'b0;
    end else if (i_irq && !in_handler) begin
      // Save the selected level and run everything at once
      saved_bits <= mode_bits;
      mode_bits  <= LPM_MODE_RST;
      in_handler <= 1'b1;
    end else if (i_return_from_interrupt_instr && in_handler) begin
      mode_bits  <= saved_bits;
      in_handler <= 1'b0;
    end else if (wr_en && is_reg(i_paddr, LPM_OFF_MODE)) begin
      mode_bits  <= i_pwdata[LPM_BIT_HI:LPM_BIT_HALT];
    end
  end

  // Module enables are writable whatever their own state
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      module_en <= LPM_ENABLE_RST;
    end else if (wr_en && is_reg(i_paddr, LPM_OFF_ENABLE)) begin
      module_en <= i_pwdata[LPM_MODULES-1:0];
    end
  end

  // Register read data, zero for unmapped and reserved bits
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      if (is_reg(i_paddr, LPM_OFF_MODE)) begin
        o_prdata <= {24'h000000, mode_bits, 4'h0};
      end else if (is_reg(i_paddr, LPM_OFF_ENABLE)) begin
        o_prdata <= {24'h000000, module_en};
      end else if (is_reg(i_paddr, LPM_OFF_STATUS)) begin
        o_prdata <= {23'h000000, in_handler, o_xtal_on, o_dco_dc_on,
                     o_loop_run, o_master_on, o_cpu_run, o_mode};
      end else begin
        o_prdata <= 32'h00000000;
      end
    end
  end

  // Clear flag: lowest oscillator frequency held until second edge
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cleared <= 1'b0;
    end else begin
      cleared <= 1'b1;
    end
  end

  // Gating outputs from the decoded state, one register stage
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cpu_run      <= 1'b0;
      o_master_on    <= 1'b0;
      o_loop_run     <= 1'b0;
      o_dco_dc_on    <= 1'b0;
      o_dco_min_freq <= 1'b1;
      o_xtal_on      <= 1'b0;
      o_module_en    <= 8'h00;
      o_mode         <= 3'h0;
    end else begin
      o_dco_min_freq <= !cleared;
      o_mode         <= cur_mode;
      o_module_en    <= module_en;
      unique case (cur_mode)
        full_run_state: begin
          o_cpu_run <= 1'b1; o_master_on <= 1'b1; o_loop_run <= cleared;
          o_dco_dc_on <= 1'b1; o_xtal_on <= 1'b1;
        end
        sleep_level_zero: begin
          o_cpu_run <= 1'b0; o_master_on <= 1'b1; o_loop_run <= cleared;
          o_dco_dc_on <= 1'b1; o_xtal_on <= 1'b1;
        end
        sleep_level_one: begin
          o_cpu_run <= 1'b0; o_master_on <= 1'b1; o_loop_run <= 1'b0;
          o_dco_dc_on <= 1'b1; o_xtal_on <= 1'b1;
        end
        sleep_level_two: begin
          o_cpu_run <= 1'b0; o_master_on <= 1'b0; o_loop_run <= 1'b0;
          o_dco_dc_on <= 1'b1; o_xtal_on <= 1'b1;
        end
        sleep_level_three: begin
          o_cpu_run <= 1'b0; o_master_on <= 1'b0; o_loop_run <= 1'b0;
          o_dco_dc_on <= 1'b0; o_xtal_on <= 1'b1;
        end
        sleep_level_four: begin
          o_cpu_run <= 1'b0; o_master_on <= 1'b0; o_loop_run <= 1'b0;
          o_dco_dc_on <= 1'b0; o_xtal_on <= 1'b0;
        end
        default: begin
          // Three-bit code has two unused values
          o_cpu_run <= 1'b1; o_master_on <= 1'b1; o_loop_run <= 1'b0;
          o_dco_dc_on <= 1'b1; o_xtal_on <= 1'b1;
        end
      endcase
    end
  end

  // Auxiliary tick: one pulse per master multiple, only while crystal runs
  // The divider freezes rather than resets so restart keeps phase
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt    <= 5'h00;
      o_aux_tick <= 1'b0;
    end else if (o_xtal_on) begin
      div_cnt    <= (div_cnt == LPM_DIV_MAX) ? 5'h00 : div_cnt + 5'h01;
      o_aux_tick <= (div_cnt == LPM_DIV_MAX);
    end else begin
      o_aux_tick <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_wake_core_runs: assert property (i_irq && !in_handler |-> ##2 o_cpu_run)
    else $error("core not released after interrupt");
  a_return_from_interrupt_instr_restores: assert property (i_return_from_interrupt_instr && in_handler |=> mode_bits == $past(saved_bits))
    else $error("return did not restore saved bits");
  a_wake_saves: assert property (i_irq && !in_handler |=> saved_bits == $past(mode_bits))
    else $error("mode bits not saved on wake");
  a_lvl_zero: assert property (cur_mode == sleep_level_zero && cleared
      |=> !o_cpu_run && o_loop_run && o_master_on)
    else $error("level zero gating wrong");
  a_lvl_one: assert property (cur_mode == sleep_level_one |=> !o_loop_run && o_master_on && !o_cpu_run)
    else $error("level one gating wrong");
  a_lvl_two: assert property (cur_mode == sleep_level_two |=> !o_master_on && o_dco_dc_on && o_xtal_on)
    else $error("level two gating wrong");
  a_lvl_three: assert property (cur_mode == sleep_level_three |=> !o_dco_dc_on && o_xtal_on && !o_loop_run)
    else $error("level three gating wrong");
  a_lvl_four: assert property (cur_mode == sleep_level_four [*2] |=> !o_xtal_on && !o_aux_tick)
    else $error("level four left crystal running");
  a_aux_period: assert property ($rose(o_aux_tick) && o_xtal_on |-> ##1 !o_aux_tick [*8])
    else $error("auxiliary tick too frequent");
  // Halt plus oscillator-off is the deepest level, code five
  a_mode_decode: assert property (mode_bits == 4'h3 |=> o_mode == 3'h5)
    else $error("mode bits decode wrong");
  a_enable_write: assert property (wr_en && is_reg(i_paddr, LPM_OFF_ENABLE)
      |-> ##2 o_module_en == $past(i_pwdata[7:0], 2))
    else $error("module enable not applied");
  a_min_freq: assert property (cleared |-> !o_dco_min_freq || !$past(cleared))
    else $error("lowest frequency held after clear");
  a_mode_write: assert property (wr_en && is_reg(i_paddr, LPM_OFF_MODE) && !i_irq && !i_return_from_interrupt_instr
      |=> mode_bits == $past(i_pwdata[7:4]))
    else $error("mode write lost");
  a_osc_reset: assert property ($rose(cleared) |-> mode_bits[1] == 1'b0)
    else $error("oscillator-off not cleared by reset");
endmodule

// [tb/lpm_far_side.sv]
// Purpose: Far-side model of the core and peripherals on the gated clocks
// Assumes: Clock enables are sampled on i_clock
// Notes:   Counts auxiliary ticks and core cycles so the bench can judge rates
`timescale 1ns/1ps
module lpm_far_side (
  input  wire logic i_clock,
  input  wire logic i_clr,
  input  wire logic i_aux_tick,
  input  wire logic i_cpu_run,
  output int        o_aux_cnt,
  output int        o_cpu_cnt
);
  // A peripheral only advances on ticks it is given; clear restarts a window
  always @(posedge i_clock) begin
    if (i_clr) begin
      o_aux_cnt <= 0;
      o_cpu_cnt <= 0;
    end else begin
      o_aux_cnt <= o_aux_cnt + int'(i_aux_tick);
      o_cpu_cnt <= o_cpu_cnt + int'(i_cpu_run);
    end
  end
endmodule

// [tb/low_power_mode_controller_bench.sv]
// Purpose: Self-checking bench for the low-power mode controller
// Assumes: Zero-wait APB slave; wake and return pulses on i_clock
// Notes:   Expected gating comes from a table model of the sleep levels
`timescale 1ns/1ps
module low_power_mode_controller_bench;
  import lpm_pkg::*;
  logic        i_clock = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_irq = 0, i_return_from_interrupt_instr = 0, clr = 1, err, o_pready, o_pslverr, o_cpu_run, o_master_on;
  logic        o_aux_tick, o_loop_run, o_dco_dc_on, o_dco_min_freq, o_xtal_on;
  logic [31:0] i_paddr = 0, i_pwdata = 0, o_prdata, rd;
  logic [7:0]  o_module_en;
  logic [2:0]  o_mode;
  int          miscompares = 0, num_checks = 0, aux_cnt, cpu_cnt, bits, en;
  always #12.5 i_clock = ~i_clock;
  lpm_controller uut (.i_clock, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_irq, .i_return_from_interrupt_instr, .o_cpu_run, .o_master_on, .o_aux_tick, .o_loop_run,
    .o_dco_dc_on, .o_dco_min_freq, .o_xtal_on, .o_module_en, .o_mode);
  lpm_far_side far (.i_clock, .i_clr(clr), .i_aux_tick(o_aux_tick), .i_cpu_run(o_cpu_run),
    .o_aux_cnt(aux_cnt), .o_cpu_cnt(cpu_cnt));
  // Level from mode bits: halt clear means run, then osc, hi and lo, hi, lo
  function automatic int level(input int b);
    if (b[4] == 1'b0) return 0;
    if (b[5]) return 5;
    if (b[7] && b[6]) return 4;
    if (b[7]) return 3;
    return b[6] ? 2 : 1;
  endfunction
  // Expected {cpu, master, loop, dc, xtal, mode}
  function automatic logic [7:0] gate(input int l);
    return {l == 0, l < 3, l < 2, l < 4, l < 5, 3'(l)};
  endfunction
  function automatic logic [31:0] stat(input int l, input logic h);
    logic [7:0] g;
    g = gate(l);
    // Status word: handler[8], xtal, dc, loop, master, core[3], level code[2:0]
    return {23'h0, h, g[3], g[4], g[5], g[6], g[7], g[2:0]};
  endfunction
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_gate(input int l);
    chk_reg("gating", {24'h0, gate(l)}, {24'h0, o_cpu_run, o_master_on, o_loop_run, o_dco_dc_on, o_xtal_on, o_mode});
  endtask
  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {24'h0, a};
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1 && ++n < 16);
    if (n == 16) miscompares++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
  endtask
  task automatic pulse(input logic r);
    @(posedge i_clock) if (r) i_return_from_interrupt_instr <= 1'b1; else i_irq <= 1'b1;
    @(posedge i_clock) {i_return_from_interrupt_instr, i_irq} <= 2'b00;
    tick(3);
  endtask
  // Aux ticks over whole divider periods; master rate is a fixed multiple
  task automatic count(input int l);
    @(posedge i_clock) clr <= 1'b1;
    @(posedge i_clock) clr <= 1'b0;
    tick(10 * LPM_MULT + 1);
    chk_reg("aux ticks", (l < 5) ? 32'd10 : 32'd0, 32'(aux_cnt));
    chk_reg("core cycles", (l == 0) ? 32'(10 * LPM_MULT) : 32'd0, 32'(cpu_cnt));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3b38));
    repeat (4) @(posedge i_clock);
    chk_reg("min freq", 32'h1, 32'(o_dco_min_freq));
    i_rstn <= 1'b1;
    tick(4);
    chk_gate(0);
    chk_reg("min freq", 32'h0, 32'(o_dco_min_freq));
    apb(0, LPM_OFF_ENABLE, 0);
    chk_reg("enable", 32'(LPM_ENABLE_RST), rd);
    $display("test reset done");
    for (bits = 0; bits < 256; bits += 16) begin
      apb(1, LPM_OFF_MODE, 32'(bits));
      tick(3);
      chk_gate(level(bits));
      apb(0, LPM_OFF_STATUS, 0);
      chk_reg("status", stat(level(bits), 1'b0), rd);
    end
    $display("test mode table done");
    repeat (4) begin
      bits = ($urandom & 32'hE0) | 32'h10;
      apb(1, LPM_OFF_MODE, 32'(bits));
      tick(3);
      pulse(1'b0);
      chk_gate(0);
      apb(0, LPM_OFF_STATUS, 0);
      chk_reg("status", stat(0, 1'b1), rd);
      pulse(1'b1);
      chk_gate(level(bits));
      apb(0, LPM_OFF_MODE, 0);
      chk_reg("mode", 32'(bits), rd);
    end
    $display("test wake done");
    apb(1, LPM_OFF_MODE, 32'h30);
    en = $urandom & 32'hFF;
    apb(1, LPM_OFF_ENABLE, 32'(en));
    apb(0, LPM_OFF_ENABLE, 0);
    chk_reg("enable", 32'(en), rd);
    chk_reg("module en", 32'(en), 32'(o_module_en));
    count(5);
    apb(1, LPM_OFF_STATUS, 32'hFFFFFFFF);
    apb(0, LPM_OFF_STATUS, 0);
    chk_reg("status", stat(5, 1'b0), rd);
    apb(1, 8'h0C, 32'hFFFFFFFF);
    chk_reg("slverr", 32'h1, 32'(err));
    apb(0, 8'h0C, 0);
    chk_reg("unmapped", 32'h1, {rd[30:0], err});
    apb(1, LPM_OFF_MODE, 0);
    tick(3);
    count(0);
    $display("test clocks done");
    wrap_up();
  end
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
